// File: hdl/clk_ctl_defines.svh
/*
  Offsets, field positions, reset values and counts for the clock-control block.
  Assumes a 32-bit Wishbone slave with word-aligned byte addresses.
*/
`ifndef CLK_CTL_DEFINES_SVH
`define CLK_CTL_DEFINES_SVH

// register byte offsets
`define OFS_SYSCLK_ENABLE 8'h00
`define OFS_SYSCLK_DISABLE 8'h04
`define OFS_SYSCLK_STATUS 8'h08
`define OFS_MASTER_CFG 8'h0c
`define OFS_PLL_A_CFG 8'h10
`define OFS_PM_STATUS 8'h14
`define OFS_IRQ_ENABLE 8'h18
`define OFS_IRQ_DISABLE 8'h1c
`define OFS_IRQ_MASK 8'h20
`define OFS_PROG_CFG0 8'h24
`define OFS_PROG_CFG1 8'h28
`define OFS_PROG_CFG2 8'h2c

// master_clock_config fields
`define MCK_CSS_LSB 0
`define MCK_CSS_MSB 1
`define MCK_PRESCALER_SELECT_LSB 4
`define MCK_PRESCALER_SELECT_MSB 6
`define MCK_MASTER_DIVIDER_LSB 8
`define MCK_MASTER_DIVIDER_MSB 9

// prog_clock_config fields
`define PCK_CSS_LSB 0
`define PCK_CSS_MSB 2
`define PCK_PRESCALER_SELECT_LSB 4
`define PCK_PRESCALER_SELECT_MSB 6

// address bits that pick one programmable clock register
`define PCK_IDX_LSB 2
`define PCK_IDX_MSB 3

// status, enable and interrupt bit positions
`define ST_PLL_A_LOCK 0
`define ST_MCK_READY 3
`define PCK_BIT_LSB 8
`define PCK_BIT_MSB 10

// master source codes
`define MCSS_SLOW 2'h0
`define MCSS_MAIN 2'h1
`define MCSS_PLL_A 2'h2
`define MCSS_USB_PLL 2'h3

// source vector indices
`define SRC_SLOW 3'h0
`define SRC_MAIN 3'h1
`define SRC_MASTER 3'h2
`define SRC_PLL_A 3'h3
`define SRC_USB_PLL 3'h4
`define SRC_LAST 3'h4

`define PRESCALER_SELECT_MAX 3'h6
`define SETTLE_EDGES 2'h2
`define NUM_PCK 3

`define RST_MCK_CSS 2'h0
`define RST_PRESCALER_SELECT 3'h0
`define RST_MASTER_DIVIDER 2'h0
`define RST_PCK_CSS 3'h0
`define RST_PLL_CFG 32'h00000000
`define RST_MASK3 3'h0
`define ZERO32 32'h00000000

`endif

// File: hdl/clk_ctl_pkg.sv
/*
  Types for the clock-control block.
  Assumes clk_ctl_defines.svh for all numeric constants.
*/
`default_nettype none
`include "clk_ctl_defines.svh"

package clk_ctl_pkg;

  typedef struct packed {
    logic src_prev;
    logic [5:0] cnt;
    logic clk;
    logic ready;
    logic [1:0] settle;
  } div_state_t;

  typedef struct packed {
    logic [2:0] pck_en;
    logic [1:0] mck_css;
    logic [2:0] mck_prescaler_select;
    logic [1:0] master_divider;
    logic [2:0][2:0] pck_css;
    logic [2:0][2:0] pck_prescaler_select;
    logic [2:0] pck_restart;
    logic [31:0] pll_cfg;
    logic [2:0] irq_mask;
    logic mck_restart;
    logic [2:0] eff_src;
    logic lock;
    logic [2:0] master_divider_cnt;
    logic proc_prev;
    logic master_clk;
    logic ack;
    logic [31:0] dat;
  } ctl_state_t;

endpackage

`default_nettype wire

// File: hdl/clk_div_if.sv
/*
  Carrier between the control core and one clock divider.
  Assumes one instance per divided clock, driven in the clk_i domain.
*/
`default_nettype none

interface clk_div_if;
  logic [2:0] sel;
  logic [2:0] prescaler_select;
  logic en;
  logic restart;
  logic clk_out;
  logic ready;

  modport ctl (output sel, output prescaler_select, output en, output restart, input clk_out, input ready);
  modport gen (input sel, input prescaler_select, input en, input restart, output clk_out, output ready);
endinterface

`default_nettype wire

// File: hdl/clk_divider.sv
/*
  Selectable power-of-two clock divider with a ready flag.
  Assumes source clocks are sampled levels, slower than clk_i.
*/
`default_nettype none
`include "clk_ctl_defines.svh"

module clk_divider (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // candidate source levels
  input wire logic [4:0] src_i,
  // control carrier
  clk_div_if.gen div
);

  clk_ctl_pkg::div_state_t st_r;
  clk_ctl_pkg::div_state_t st_nxt;
  logic src;
  logic [2:0] prescaler_select;

  always_comb begin
    src = (div.sel > `SRC_LAST) ? src_i[`SRC_SLOW] : src_i[div.sel];
    prescaler_select = (div.prescaler_select > `PRESCALER_SELECT_MAX) ? `PRESCALER_SELECT_MAX : div.prescaler_select;
    st_nxt = st_r;
    st_nxt.src_prev = src;
    if (div.restart || !div.en) begin
      st_nxt.cnt = 6'h00;
      st_nxt.clk = 1'b0;
      st_nxt.ready = 1'b0;
      st_nxt.settle = 2'h0;
    end else begin
      if (src && !st_r.src_prev) begin
        st_nxt.cnt = st_r.cnt + 6'h01;
        if (st_r.settle != `SETTLE_EDGES) begin
          st_nxt.settle = st_r.settle + 2'h1;
        end else begin
          st_nxt.ready = 1'b1; // [R11]
        end
      end
      // code 0 passes the source, code n taps bit n-1 for divide by 2^n
      st_nxt.clk = (prescaler_select == 3'h0) ? src : st_nxt.cnt[prescaler_select - 3'h1]; // [R10] [R15]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign div.clk_out = st_r.clk;
  assign div.ready = st_r.ready;

endmodule

`default_nettype wire

// File: hdl/clk_ctl.sv
/*
  Master and programmable clock control with a Wishbone register slave.
  Assumes source clocks and PLL lock arrive as levels synchronous to clk_i.
*/
// Functional notes
// [R01] master ready drops on any master source, divider or prescaler change
// [R02] software waits for master ready before using reconfigured clocks
// [R03] main or slow source: write select, wait, then prescaler, wait
// [R04] PLL source: write divider, wait, then select, wait
// [R05] PLL reprogrammed while feeding master: ready low until relock, lock first
// [R06] unlocked PLL feeding master makes master run from slow clock
// [R07] config 0x01 then 0x11 gives master as main over two
// [R08] three programmable clocks, set enable, clear disable, status, off at reset
// [R09] programmable source: main, slow, master, PLL A, USB PLL; slow default
// [R10] programmable output is source over 1..64, prescaler resets to zero
// [R11] enabled programmable clock sets ready flag and interrupt if enabled
// [R12] software waits for programmable ready by polling or interrupt
// [R13] source and prescaler taken together in one write
// [R14] software disables, reconfigures, re-enables, then waits for ready
// [R15] prescaler codes are consecutive, zero divides by one, doubling each
`default_nettype none
`include "clk_ctl_defines.svh"

module clk_ctl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // source clocks and pll
  input wire logic slow_clock_i,
  input wire logic main_clock_i,
  input wire logic pll_a_clock_i,
  input wire logic usb_pll_clock_i,
  input wire logic pll_a_lock_i,
  output logic [31:0] pll_a_config_o,
  // generated clocks
  output logic proc_clock_o,
  output logic master_clock_o,
  output logic [2:0] prog_clock_out_o,
  output logic irq_o
);

  clk_ctl_pkg::ctl_state_t st_r;
  clk_ctl_pkg::ctl_state_t st_nxt;
  clk_div_if mck_if ();
  clk_div_if pck_if [`NUM_PCK] ();
  logic [2:0] pck_ready;
  logic mck_ready;
  logic [31:0] wmask;
  logic [31:0] rdat;
  logic req;
  logic wr;
  logic [2:0] src_eff;
  logic [31:0] mck_word;
  logic [31:0] pll_word;

  function automatic logic [2:0] mcss_to_src(input logic [1:0] clock_source_select);
    case (clock_source_select)
      `MCSS_MAIN: mcss_to_src = `SRC_MAIN;
      `MCSS_PLL_A: mcss_to_src = `SRC_PLL_A;
      `MCSS_USB_PLL: mcss_to_src = `SRC_USB_PLL;
      default: mcss_to_src = `SRC_SLOW;
    endcase
  endfunction

  function automatic logic [1:0] pck_index(input logic [7:0] a);
    pck_index = a[`PCK_IDX_MSB:`PCK_IDX_LSB] - 2'h1;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
    merge = (old & ~msk) | (dat_i & msk);
  endfunction

  // sources seen by the dividers
  logic [4:0] src_vec;
  assign src_vec = {usb_pll_clock_i, pll_a_clock_i, st_r.master_clk, main_clock_i, slow_clock_i};

  assign mck_if.sel = st_r.eff_src;
  assign mck_if.prescaler_select = st_r.mck_prescaler_select;
  assign mck_if.en = 1'b1;
  assign mck_if.restart = st_r.mck_restart;
  clk_divider mck_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(src_vec),
    .div(mck_if.gen)
  );

  for (genvar g = 0; g < `NUM_PCK; g++) begin : g_pck
    assign pck_if[g].sel = st_r.pck_css[g];
    assign pck_if[g].prescaler_select = st_r.pck_prescaler_select[g];
    assign pck_if[g].en = st_r.pck_en[g];
    assign pck_if[g].restart = st_r.pck_restart[g];
    assign pck_ready[g] = pck_if[g].ready;
    assign prog_clock_out_o[g] = pck_if[g].clk_out;
    clk_divider pck_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .src_i(src_vec),
      .div(pck_if[g].gen)
    );
  end

  // ready only after settling on the selected source and, on the pll, after lock
  assign mck_ready = mck_if.ready && !st_r.mck_restart
    && !(st_r.mck_css == `MCSS_PLL_A && !st_r.lock)
    && st_r.eff_src == mcss_to_src(st_r.mck_css); // [R01] [R05]

  always_comb begin
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    req = cyc_i && stb_i;
    wr = req && we_i && st_r.ack;
    mck_word = `ZERO32;
    mck_word[`MCK_CSS_MSB:`MCK_CSS_LSB] = st_r.mck_css;
    mck_word[`MCK_PRESCALER_SELECT_MSB:`MCK_PRESCALER_SELECT_LSB] = st_r.mck_prescaler_select;
    mck_word[`MCK_MASTER_DIVIDER_MSB:`MCK_MASTER_DIVIDER_LSB] = st_r.master_divider;
    pll_word = merge(st_r.pll_cfg, wmask);
    rdat = `ZERO32;
    case (adr_i)
      `OFS_SYSCLK_STATUS: rdat[`PCK_BIT_MSB:`PCK_BIT_LSB] = st_r.pck_en; // [R08]
      `OFS_MASTER_CFG: rdat = mck_word;
      `OFS_PLL_A_CFG: rdat = st_r.pll_cfg;
      `OFS_PM_STATUS: begin
        rdat[`ST_PLL_A_LOCK] = st_r.lock;
        rdat[`ST_MCK_READY] = mck_ready;
        rdat[`PCK_BIT_MSB:`PCK_BIT_LSB] = pck_ready;
      end
      `OFS_IRQ_MASK: rdat[`PCK_BIT_MSB:`PCK_BIT_LSB] = st_r.irq_mask;
      `OFS_PROG_CFG0, `OFS_PROG_CFG1, `OFS_PROG_CFG2: begin
        rdat[`PCK_CSS_MSB:`PCK_CSS_LSB] = st_r.pck_css[pck_index(adr_i)];
        rdat[`PCK_PRESCALER_SELECT_MSB:`PCK_PRESCALER_SELECT_LSB] = st_r.pck_prescaler_select[pck_index(adr_i)];
      end
      default: rdat = `ZERO32;
    endcase

    st_nxt = st_r;
    st_nxt.ack = req && !st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.dat = rdat;
    end
    st_nxt.lock = pll_a_lock_i;
    st_nxt.pck_restart = 3'h0;
    st_nxt.mck_restart = 1'b0;
    // unlocked pll falls back to the slow clock
    src_eff = (st_r.mck_css == `MCSS_PLL_A && !st_r.lock) ?
      `SRC_SLOW : mcss_to_src(st_r.mck_css); // [R06]
    st_nxt.eff_src = src_eff;
    if (src_eff != st_r.eff_src) begin
      st_nxt.mck_restart = 1'b1; // [R05]
    end

    if (wr) begin
      case (adr_i)
        `OFS_SYSCLK_ENABLE: st_nxt.pck_en = st_r.pck_en
          | (dat_i[`PCK_BIT_MSB:`PCK_BIT_LSB] & wmask[`PCK_BIT_MSB:`PCK_BIT_LSB]); // [R08]
        `OFS_SYSCLK_DISABLE: st_nxt.pck_en = st_r.pck_en
          & ~(dat_i[`PCK_BIT_MSB:`PCK_BIT_LSB] & wmask[`PCK_BIT_MSB:`PCK_BIT_LSB]); // [R08]
        `OFS_MASTER_CFG: begin
          mck_word = merge(mck_word, wmask);
          st_nxt.mck_css = mck_word[`MCK_CSS_MSB:`MCK_CSS_LSB];
          st_nxt.mck_prescaler_select = mck_word[`MCK_PRESCALER_SELECT_MSB:`MCK_PRESCALER_SELECT_LSB]; // [R07]
          st_nxt.master_divider = mck_word[`MCK_MASTER_DIVIDER_MSB:`MCK_MASTER_DIVIDER_LSB];
          st_nxt.mck_restart = 1'b1; // [R01]
        end
        `OFS_PLL_A_CFG: begin
          st_nxt.pll_cfg = pll_word;
          if (st_r.mck_css == `MCSS_PLL_A) begin
            st_nxt.mck_restart = 1'b1; // [R05]
          end
        end
        `OFS_IRQ_ENABLE: st_nxt.irq_mask = st_r.irq_mask
          | (dat_i[`PCK_BIT_MSB:`PCK_BIT_LSB] & wmask[`PCK_BIT_MSB:`PCK_BIT_LSB]);
        `OFS_IRQ_DISABLE: st_nxt.irq_mask = st_r.irq_mask
          & ~(dat_i[`PCK_BIT_MSB:`PCK_BIT_LSB] & wmask[`PCK_BIT_MSB:`PCK_BIT_LSB]);
        `OFS_PROG_CFG0, `OFS_PROG_CFG1, `OFS_PROG_CFG2: begin
          // source and prescaler land in the same write
          if (wmask[0]) begin
            st_nxt.pck_css[pck_index(adr_i)] = dat_i[`PCK_CSS_MSB:`PCK_CSS_LSB]; // [R13] [R09]
            st_nxt.pck_prescaler_select[pck_index(adr_i)] = dat_i[`PCK_PRESCALER_SELECT_MSB:`PCK_PRESCALER_SELECT_LSB]; // [R13]
            st_nxt.pck_restart[pck_index(adr_i)] = 1'b1;
          end
        end
        default: st_nxt.dat = st_r.dat;
      endcase
    end

    // master divider stage after the processor clock
    st_nxt.proc_prev = mck_if.clk_out;
    if (mck_if.clk_out && !st_r.proc_prev) begin
      st_nxt.master_divider_cnt = st_r.master_divider_cnt + 3'h1;
    end
    st_nxt.master_clk = (st_r.master_divider == `RST_MASTER_DIVIDER) ? mck_if.clk_out
      : st_nxt.master_divider_cnt[st_r.master_divider - 2'h1]; // [R07]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.mck_css <= `RST_MCK_CSS;
      st_r.mck_prescaler_select <= `RST_PRESCALER_SELECT;
      st_r.master_divider <= `RST_MASTER_DIVIDER;
      st_r.pck_en <= `RST_MASK3; // [R08]
      st_r.pck_css <= {`RST_PCK_CSS, `RST_PCK_CSS, `RST_PCK_CSS}; // [R09]
      st_r.pck_prescaler_select <= {`RST_PRESCALER_SELECT, `RST_PRESCALER_SELECT, `RST_PRESCALER_SELECT}; // [R10]
      st_r.pll_cfg <= `RST_PLL_CFG;
      st_r.irq_mask <= `RST_MASK3;
      st_r.eff_src <= `SRC_SLOW;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack_o = st_r.ack && cyc_i && stb_i;
  assign dat_o = st_r.dat;
  assign pll_a_config_o = st_r.pll_cfg;
  assign proc_clock_o = mck_if.clk_out;
  assign master_clock_o = st_r.master_clk;
  assign irq_o = |(pck_ready & st_r.irq_mask); // [R11]

endmodule

`default_nettype wire

// File: tb/clk_ctl_props.sv
/*
  Port-level checks of the clock-control block.
  Assumes it is bound onto clk_ctl; one clock domain.
*/
`default_nettype none
module clk_ctl_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // sources and pll
  input wire logic slow_clock_i,
  input wire logic main_clock_i,
  input wire logic pll_a_clock_i,
  input wire logic usb_pll_clock_i,
  input wire logic pll_a_lock_i,
  input wire logic [31:0] pll_a_config_o,
  // generated clocks
  input wire logic proc_clock_o,
  input wire logic master_clock_o,
  input wire logic [2:0] prog_clock_out_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] pll_w_r;
  always_ff @(posedge clk_i) begin
    if (ack_o && we_i && adr_i == 8'h10) pll_w_r <= dat_i;
  end
  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_resp;
    $rose(cyc_i && stb_i) |=> ack_o;
  endproperty
  property p_ack_req;
    ack_o |-> cyc_i && stb_i;
  endproperty
  property p_dat_hold;
    ack_o |=> ($stable(dat_o)) [*2];
  endproperty
  property p_unmapped;
    ack_o && !we_i && adr_i > 8'h2c |-> dat_o == 32'h0;
  endproperty
  property p_wo_read;
    ack_o && !we_i && (adr_i == 8'h00 || adr_i == 8'h04) |-> dat_o == 32'h0;
  endproperty
  property p_pll_wr;
    ack_o && we_i && adr_i == 8'h10 && sel_i == 4'hf |-> ##[1:2] pll_a_config_o == pll_w_r;
  endproperty
  property p_rst_out;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> prog_clock_out_o == 3'h0 && !irq_o && !ack_o && pll_a_config_o == 32'h0;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed early");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");
  a_pll_wr: assert property (p_pll_wr) else $error("pll config not updated");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  c_mck_wr: cover property (ack_o && we_i && adr_i == 8'h0c);
  c_irq: cover property ($rose(irq_o));
  c_pck: cover property ($rose(prog_clock_out_o[2]));
endmodule
bind clk_ctl clk_ctl_props props_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .slow_clock_i(slow_clock_i), .main_clock_i(main_clock_i),
  .pll_a_clock_i(pll_a_clock_i), .usb_pll_clock_i(usb_pll_clock_i),
  .pll_a_lock_i(pll_a_lock_i), .pll_a_config_o(pll_a_config_o),
  .proc_clock_o(proc_clock_o), .master_clock_o(master_clock_o),
  .prog_clock_out_o(prog_clock_out_o), .irq_o(irq_o)
);
`default_nettype wire

// File: tb/tb_clk_ctl.sv
/*
  Register-level tests of the clock-control block.
  Assumes clk_ctl and its checker are compiled first.
*/
`default_nettype none
module tb_clk_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pll_a_lock_i = 1;
  logic slow_clock_i = 0, main_clock_i = 0, pll_a_clock_i = 0, usb_pll_clock_i = 0;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, pll_a_config_o, q;
  logic ack_o, proc_clock_o, master_clock_o, irq_o;
  logic [2:0] prog_clock_out_o;
  logic [7:0] ra[7] = '{8'h08, 8'h0c, 8'h24, 8'h28, 8'h2c, 8'h00, 8'h40};
  int sp[5] = '{32, 8, 12, 6, 4};
  int miscompares = 0, checked = 0, cyc_n = 0;
  clk_ctl clk_ctl_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .slow_clock_i(slow_clock_i), .main_clock_i(main_clock_i),
    .pll_a_clock_i(pll_a_clock_i), .usb_pll_clock_i(usb_pll_clock_i),
    .pll_a_lock_i(pll_a_lock_i), .pll_a_config_o(pll_a_config_o),
    .proc_clock_o(proc_clock_o), .master_clock_o(master_clock_o),
    .prog_clock_out_o(prog_clock_out_o), .irq_o(irq_o)
  );
  initial forever #10 clk_i = ~clk_i;
  // source half periods 16, 4, 3 and 2 cycles
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n % 16 == 0) slow_clock_i <= ~slow_clock_i;
    if (cyc_n % 4 == 0) main_clock_i <= ~main_clock_i;
    if (cyc_n % 3 == 0) pll_a_clock_i <= ~pll_a_clock_i;
    if (cyc_n % 2 == 0) usb_pll_clock_i <= ~usb_pll_clock_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) chk("ack", 32'h0, 32'h1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    q = 32'h0;
    while (q[b] !== 1'b1 && n < 200) begin
      xfer(1'b0, 8'h14, 32'h0);
      n++;
    end
    chk("ready flag", q[b], 32'h1);
  endtask
  function automatic logic sg(input int s);
    logic [4:0] v;
    v = {proc_clock_o, master_clock_o, prog_clock_out_o};
    return v[s];
  endfunction
  // period of the third rise, the first one may follow a restart
  task automatic per(input int s, input int e, input string nm);
    int n, r;
    logic l;
    n = 0;
    r = 0;
    l = sg(s);
    while (r < 3 && n < 3000) begin
      @(posedge clk_i);
      n++;
      if (sg(s) === 1'b1 && l === 1'b0) r++;
      if (sg(s) === 1'b1 && l === 1'b0 && r == 2) n = 0;
      l = sg(s);
    end
    chk(nm, n, e);
  endtask
  task automatic mck(input logic [31:0] v);
    xfer(1'b1, 8'h0c, v);
    xfer(1'b0, 8'h14, 32'h0);
    chk("master ready low", q[3], 32'h0);
    poll(3);
  endtask
  task automatic pck(input int n, input logic [2:0] src, input logic [2:0] pr, input int e);
    logic [31:0] b;
    b = 32'h100 << n;
    xfer(1'b1, 8'h04, b);
    xfer(1'b0, 8'h08, 32'h0);
    chk("prog status off", q & b, 32'h0);
    chk("prog out off", prog_clock_out_o[n], 32'h0);
    xfer(1'b1, 8'h24 + 8'(4 * n), {25'h0, pr, 1'b0, src});
    xfer(1'b1, 8'h00, b);
    poll(8 + n);
    xfer(1'b0, 8'h08, 32'h0);
    chk("prog status on", q & b, b);
    per(n, e, "prog period");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 32'h0);
      chk("reset value", q, 32'h0);
    end
    $display("test reset values done");
    mck(32'h1);
    mck(32'h11);
    per(3, 16, "master period");
    per(4, 16, "proc period");
    $display("test master main done");
    mck(32'h111);
    mck(32'h102);
    per(4, 6, "proc on pll");
    per(3, 12, "master on pll");
    pll_a_lock_i <= 1'b0;
    xfer(1'b1, 8'h10, 32'h00a55a0f);
    chk("pll config", pll_a_config_o, 32'h00a55a0f);
    per(4, 32, "proc on slow");
    xfer(1'b0, 8'h14, 32'h0);
    chk("status unlocked", q & 32'h9, 32'h0);
    pll_a_lock_i <= 1'b1;
    poll(3);
    chk("lock flag", q[0], 32'h1);
    per(4, 6, "proc relocked");
    $display("test pll switch done");
    foreach (sp[i]) pck(0, 3'(i), 3'h0, sp[i]);
    for (int k = 0; k < 7; k++) pck(1, 3'h1, 3'(k), 8 << k);
    pck(2, 3'h4, 3'h3, 32);
    pck(2, 3'h1, 3'h7, 512);
    mck(32'h2);
    mck(32'h3);
    per(4, 4, "proc on usb pll");
    per(3, 4, "master undivided");
    $display("test prog clocks done");
    chk("irq masked", irq_o, 32'h0);
    xfer(1'b1, 8'h18, 32'h100);
    chk("irq raised", irq_o, 32'h1);
    xfer(1'b0, 8'h20, 32'h0);
    chk("irq mask", q, 32'h100);
    xfer(1'b1, 8'h04, 32'h100);
    @(posedge clk_i);
    chk("irq after disable", irq_o, 32'h0);
    xfer(1'b1, 8'h00, 32'h100);
    poll(8);
    chk("irq after enable", irq_o, 32'h1);
    xfer(1'b1, 8'h1c, 32'h100);
    chk("irq unmasked off", irq_o, 32'h0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(1'b0, 8'h08, 32'h0);
    chk("status after reset", q, 32'h0);
    $display("test irq and reset done");
    tally_and_finish;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
